/* hw/tfg_regs.svh */
// register offsets, field positions, reset values and counts of the test frame generator
`ifndef TFG_REGS_SVH
`define TFG_REGS_SVH

`define TFG_ADDR_CTRL 5'h1D
`define TFG_ADDR_PAT 5'h1E

`define TFG_BIT_ENABLE 15
`define TFG_BIT_RUN 14
`define TFG_BIT_CONT 13
`define TFG_LEN_HI 12
`define TFG_LEN_LO 11
`define TFG_BIT_GAP 10
`define TFG_DA_HI 9
`define TFG_DA_LO 6
`define TFG_SA_HI 5
`define TFG_SA_LO 2
`define TFG_BIT_RANDOM 1
`define TFG_BIT_BADFCS 0

`define TFG_CTRL_RESET 16'h0040
`define TFG_PAT_RESET 16'h0000

`define TFG_LEN_125 14'd125
`define TFG_LEN_64 14'd64
`define TFG_LEN_1518 14'd1518
`define TFG_LEN_JUMBO 10000

`define TFG_GAP_SHORT_BITS 96
`define TFG_GAP_LONG_BITS 8192
`define TFG_BITS_PER_BYTE 8

`define TFG_FRAME_TOTAL 30000000
`define TFG_BLOCK_FRAMES 10000

`define TFG_PREAMBLE_BYTES 7
`define TFG_PREAMBLE 8'h55
`define TFG_SFD 8'hD5
`define TFG_ADDR_FILL 8'hFF
`define TFG_TYPE_HI 8'h88
`define TFG_TYPE_LO 8'hB5
`define TFG_PAYLOAD_START 14'd14
`define TFG_FCS_BYTES 14'd4
`define TFG_CRC_POLY 32'hEDB88320
`define TFG_CRC_INIT 32'hFFFFFFFF
`define TFG_PRBS_SEED 32'h0000ACE1
`define TFG_PRBS_POLY 32'h80200003

`endif

/* hw/tfg_pkg.sv */
// types shared by the test frame generator modules
package tfg_pkg;
   typedef logic [7:0] tfg_byte_t;
   typedef logic [15:0] tfg_word_t;
   typedef logic [4:0] tfg_addr_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PRE = 5'h02,
      ST_BODY = 5'h04,
      ST_FCS = 5'h08,
      ST_GAP = 5'h10
   } tfg_state_t;
endpackage

/* hw/tfg_crc32.sv */
// byte-wide reflected CRC-32 accumulator
`timescale 1ns/1ns
`include "tfg_regs.svh"
module tfg_crc32 (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic init_i,
   input wire logic en_i,
   input wire tfg_pkg::tfg_byte_t data_i,
   output logic [31:0] crc_o
);
   import tfg_pkg::*;

   function automatic logic [31:0] crc_step(input logic [31:0] c, input tfg_byte_t d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `TFG_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc_o <= `TFG_CRC_INIT;
      end else if (init_i) begin
         crc_o <= `TFG_CRC_INIT;
      end else if (en_i) begin
         crc_o <= crc_step(crc_o, data_i);
      end
   end
endmodule

/* hw/tfg_prbs.sv */
// pseudo-random payload byte source, eight lfsr steps per byte
`timescale 1ns/1ns
`include "tfg_regs.svh"
module tfg_prbs (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic seed_i,
   input wire logic step_i,
   output tfg_pkg::tfg_byte_t byte_o
);
   import tfg_pkg::*;

   logic [31:0] lfsr_q;

   function automatic logic [31:0] lfsr_adv(input logic [31:0] s);
      logic [31:0] r;
      r = s;
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `TFG_PRBS_POLY) : (r >> 1);
      end
      return r;
   endfunction

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lfsr_q <= `TFG_PRBS_SEED;
      end else if (seed_i) begin
         lfsr_q <= `TFG_PRBS_SEED;
      end else if (step_i) begin
         lfsr_q <= lfsr_adv(lfsr_q);
      end
   end

   assign byte_o = lfsr_q[7:0];
endmodule

/* hw/tfg_top.sv */
// test frame generator: control registers, frame sequencer and transmit path mux
// Functional notes
// - frames go out only while both the enable and run bits are set, and clearing run stops it.
// - with the duration bit set frames go out without end, counted in blocks of ten thousand.
// - a run started with the duration bit clear sends exactly thirty million frames then stops.
// - clearing the duration bit in continuous mode stops at the next multiple of ten thousand.
// - the length field picks 125, 64, 1518 or 10,000-byte frames.
// - frames are spaced by 96 bit times, or 8,192 when the gap bit is set.
// - destination address is all ones with its low nibble from bits 9:6, reset 0001.
// - source address is all ones with its low nibble from bits 5:2, reset 0000.
// - payload is random when the payload-type bit is set, else the fixed pattern word.
// - bit 0 set makes every frame carry a wrong check sequence, clear a correct one.
// - in fixed mode the 16-bit pattern register repeats through the whole payload.
`timescale 1ns/1ns
`include "tfg_regs.svh"
module tfg_top #(
   parameter int unsigned FRAME_TOTAL = `TFG_FRAME_TOTAL,
   parameter int unsigned BLOCK_FRAMES = `TFG_BLOCK_FRAMES,
   parameter int unsigned JUMBO_BYTES = `TFG_LEN_JUMBO
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic REG_PAGE1_I,
   input wire logic REG_WE_I,
   input wire tfg_pkg::tfg_addr_t REG_ADDR_I,
   input wire tfg_pkg::tfg_word_t REG_WDATA_I,
   output tfg_pkg::tfg_word_t REG_RDATA_O,
   input wire tfg_pkg::tfg_byte_t MAC_TXD_I,
   input wire logic MAC_TX_EN_I,
   input wire logic MAC_TX_ER_I,
   output tfg_pkg::tfg_byte_t TX_DATA_O,
   output logic TX_EN_O,
   output logic TX_ER_O,
   output logic GEN_BUSY_O
);
   import tfg_pkg::*;

   localparam int unsigned GAP_SHORT = `TFG_GAP_SHORT_BITS / `TFG_BITS_PER_BYTE;
   localparam int unsigned GAP_LONG = `TFG_GAP_LONG_BITS / `TFG_BITS_PER_BYTE;

   logic rst_meta_q;
   logic rst_n_q;
   tfg_word_t ctrl_q;
   tfg_word_t pat_q;
   tfg_state_t state_q;
   logic [13:0] pos_q;
   logic [13:0] len_q;
   logic gap_long_q;
   logic [3:0] da_q;
   logic [3:0] sa_q;
   logic rnd_q;
   logic bad_q;
   tfg_word_t pat_run_q;
   logic cont_q;
   logic stop_q;
   logic armed_q;
   logic [24:0] frames_q;
   logic [13:0] blk_q;
   tfg_byte_t gen_byte;
   tfg_byte_t rnd_byte;
   logic [31:0] crc;
   logic [31:0] fcs_word;
   logic go;
   logic start;
   logic frame_end;
   logic gap_end;
   logic [13:0] body_last;
   logic [13:0] gap_last;
   logic [13:0] pay_idx;
   logic [24:0] frames_nx;
   logic [13:0] blk_nx;

   function automatic logic [13:0] frame_len(input logic [1:0] sel);
      case (sel)
         2'b00: frame_len = `TFG_LEN_125;
         2'b01: frame_len = `TFG_LEN_64;
         2'b10: frame_len = `TFG_LEN_1518;
         default: frame_len = JUMBO_BYTES[13:0];
      endcase
   endfunction

   // reset released through two flops
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // management registers on extended page 1
   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= `TFG_CTRL_RESET;
         pat_q <= `TFG_PAT_RESET;
      end else if (REG_WE_I && REG_PAGE1_I) begin
         if (REG_ADDR_I == `TFG_ADDR_CTRL) begin
            ctrl_q <= REG_WDATA_I;
         end
         if (REG_ADDR_I == `TFG_ADDR_PAT) begin
            pat_q <= REG_WDATA_I;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         REG_RDATA_O <= 16'h0000;
      end else if (REG_PAGE1_I && REG_ADDR_I == `TFG_ADDR_CTRL) begin
         REG_RDATA_O <= ctrl_q;
      end else if (REG_PAGE1_I && REG_ADDR_I == `TFG_ADDR_PAT) begin
         REG_RDATA_O <= pat_q;
      end else begin
         REG_RDATA_O <= 16'h0000;
      end
   end

   assign go = ctrl_q[`TFG_BIT_ENABLE] && ctrl_q[`TFG_BIT_RUN];
   // a finished run waits for enable or run to drop before it may start again
   assign start = (state_q == ST_IDLE) && go && armed_q;
   assign body_last = len_q - `TFG_FCS_BYTES - 14'd1;
   assign gap_last = gap_long_q ? 14'(GAP_LONG - 1) : 14'(GAP_SHORT - 1);
   assign frame_end = (state_q == ST_FCS) && (pos_q == `TFG_FCS_BYTES - 14'd1);
   assign gap_end = (state_q == ST_GAP) && (pos_q == gap_last);
   assign pay_idx = pos_q - `TFG_PAYLOAD_START;
   assign frames_nx = frames_q + 25'd1;
   assign blk_nx = (blk_q == 14'(BLOCK_FRAMES - 1)) ? 14'd0 : blk_q + 14'd1;

   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         armed_q <= 1'b1;
      end else if (!go) begin
         armed_q <= 1'b1;
      end else if (start) begin
         armed_q <= 1'b0;
      end
   end

   // configuration captured at start, so mid-run edits other than clearing the duration, run or enable bits wait for a restart
   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         len_q <= `TFG_LEN_125;
         gap_long_q <= 1'b0;
         da_q <= 4'h1;
         sa_q <= 4'h0;
         rnd_q <= 1'b0;
         bad_q <= 1'b0;
         pat_run_q <= `TFG_PAT_RESET;
         cont_q <= 1'b0;
      end else if (start) begin
         len_q <= frame_len(ctrl_q[`TFG_LEN_HI:`TFG_LEN_LO]);
         gap_long_q <= ctrl_q[`TFG_BIT_GAP];
         da_q <= ctrl_q[`TFG_DA_HI:`TFG_DA_LO];
         sa_q <= ctrl_q[`TFG_SA_HI:`TFG_SA_LO];
         rnd_q <= ctrl_q[`TFG_BIT_RANDOM];
         bad_q <= ctrl_q[`TFG_BIT_BADFCS];
         pat_run_q <= pat_q;
         cont_q <= ctrl_q[`TFG_BIT_CONT];
      end
   end

   // frame counting and the decision to end the run
   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         frames_q <= 25'd0;
         blk_q <= 14'd0;
         stop_q <= 1'b0;
      end else if (start) begin
         frames_q <= 25'd0;
         blk_q <= 14'd0;
         stop_q <= 1'b0;
      end else if (frame_end) begin
         frames_q <= frames_nx;
         blk_q <= blk_nx;
         if (!cont_q && frames_nx == 25'(FRAME_TOTAL)) begin
            stop_q <= 1'b1;
         end else if (cont_q && !ctrl_q[`TFG_BIT_CONT] && blk_nx == 14'd0) begin
            stop_q <= 1'b1;
         end
      end
   end

   // sequencer; clearing run lets the frame on the wire finish cleanly
   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         pos_q <= 14'd0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               pos_q <= 14'd0;
               if (start) begin
                  state_q <= ST_PRE;
               end
            end
            ST_PRE: begin
               if (pos_q == 14'(`TFG_PREAMBLE_BYTES)) begin
                  state_q <= ST_BODY;
                  pos_q <= 14'd0;
               end else begin
                  pos_q <= pos_q + 14'd1;
               end
            end
            ST_BODY: begin
               if (pos_q == body_last) begin
                  state_q <= ST_FCS;
                  pos_q <= 14'd0;
               end else begin
                  pos_q <= pos_q + 14'd1;
               end
            end
            ST_FCS: begin
               if (frame_end) begin
                  state_q <= ST_GAP;
                  pos_q <= 14'd0;
               end else begin
                  pos_q <= pos_q + 14'd1;
               end
            end
            ST_GAP: begin
               if (gap_end) begin
                  pos_q <= 14'd0;
                  if (stop_q || !go) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_PRE;
                  end
               end else begin
                  pos_q <= pos_q + 14'd1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               pos_q <= 14'd0;
            end
         endcase
      end
   end

   assign fcs_word = bad_q ? crc : ~crc;

   always_comb begin
      gen_byte = 8'h00;
      case (state_q)
         ST_PRE: begin
            gen_byte = (pos_q == 14'(`TFG_PREAMBLE_BYTES)) ? `TFG_SFD : `TFG_PREAMBLE;
         end
         ST_BODY: begin
            if (pos_q == 14'd5) begin
               gen_byte = {4'hF, da_q};
            end else if (pos_q == 14'd11) begin
               gen_byte = {4'hF, sa_q};
            end else if (pos_q < 14'd12) begin
               gen_byte = `TFG_ADDR_FILL;
            end else if (pos_q == 14'd12) begin
               gen_byte = `TFG_TYPE_HI;
            end else if (pos_q == 14'd13) begin
               gen_byte = `TFG_TYPE_LO;
            end else if (rnd_q) begin
               gen_byte = rnd_byte;
            end else begin
               gen_byte = pay_idx[0] ? pat_run_q[7:0] : pat_run_q[15:8];
            end
         end
         ST_FCS: begin
            gen_byte = fcs_word[8 * pos_q[1:0] +: 8];
         end
         default: begin
            gen_byte = 8'h00;
         end
      endcase
   end

   tfg_crc32 u_crc (
      .clk_i(CLK_I),
      .rst_n_i(rst_n_q),
      .init_i(state_q == ST_PRE),
      .en_i(state_q == ST_BODY),
      .data_i(gen_byte),
      .crc_o(crc)
   );

   tfg_prbs u_prbs (
      .clk_i(CLK_I),
      .rst_n_i(rst_n_q),
      .seed_i(start),
      .step_i(state_q == ST_BODY && pos_q >= `TFG_PAYLOAD_START && rnd_q),
      .byte_o(rnd_byte)
   );

   // transmit path: own frames replace the MAC stream while a run is active
   always_ff @(posedge CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         TX_DATA_O <= 8'h00;
         TX_EN_O <= 1'b0;
         TX_ER_O <= 1'b0;
         GEN_BUSY_O <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         TX_DATA_O <= gen_byte;
         TX_EN_O <= (state_q == ST_PRE) || (state_q == ST_BODY) || (state_q == ST_FCS);
         TX_ER_O <= 1'b0;
         GEN_BUSY_O <= 1'b1;
      end else begin
         TX_DATA_O <= MAC_TXD_I;
         TX_EN_O <= MAC_TX_EN_I;
         TX_ER_O <= MAC_TX_ER_I;
         GEN_BUSY_O <= 1'b0;
      end
   end
endmodule

/* tb/tfg_top_props.sv */
// assertion checker bound to the test frame generator top
`timescale 1ns/1ns
module tfg_top_props #(
   parameter int unsigned JUMBO_BYTES = 10000
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic REG_PAGE1_I,
   input wire logic REG_WE_I,
   input wire tfg_pkg::tfg_addr_t REG_ADDR_I,
   input wire tfg_pkg::tfg_word_t REG_WDATA_I,
   input wire tfg_pkg::tfg_word_t REG_RDATA_O,
   input wire tfg_pkg::tfg_byte_t MAC_TXD_I,
   input wire logic MAC_TX_EN_I,
   input wire logic MAC_TX_ER_I,
   input wire tfg_pkg::tfg_byte_t TX_DATA_O,
   input wire logic TX_EN_O,
   input wire logic TX_ER_O,
   input wire logic GEN_BUSY_O
);
   import tfg_pkg::*;
   logic [2:0] up_q;
   logic run_q;
   logic [15:0] hi_q;
   logic [10:0] gap_q;
   logic ctl_wr;
   assign ctl_wr = REG_WE_I && REG_PAGE1_I && REG_ADDR_I == 5'h1D;
   // up_q skips the cycles where the internal reset copy still lags
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         up_q <= 3'h0;
         run_q <= 1'b0;
         hi_q <= 16'h0000;
         gap_q <= 11'h000;
      end else begin
         if (up_q != 3'h4) up_q <= up_q + 3'h1;
         if (ctl_wr) run_q <= REG_WDATA_I[14];
         hi_q <= TX_EN_O ? hi_q + 16'h0001 : 16'h0000;
         gap_q <= (TX_EN_O || !GEN_BUSY_O) ? 11'h000 : gap_q + 11'h001;
      end
   end
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!NRST_I);
   sequence preamble_s;
      TX_DATA_O == 8'h55 [*7] ##1 TX_DATA_O == 8'hD5;
   endsequence
   sequence dest_fill_s;
      TX_DATA_O == 8'hFF [*5];
   endsequence
   sequence pat_wr_s;
      REG_WE_I && REG_PAGE1_I && REG_ADDR_I == 5'h1E ##1 REG_ADDR_I == 5'h1E && !REG_WE_I;
   endsequence
   pass_thru_a: assert property (up_q == 3'h4 && !GEN_BUSY_O && !$past(GEN_BUSY_O) |->
      TX_EN_O == $past(MAC_TX_EN_I) && TX_ER_O == $past(MAC_TX_ER_I)
      && TX_DATA_O == $past(MAC_TXD_I)) else $error("idle path does not follow mac");
   busy_no_er_a: assert property (GEN_BUSY_O && $past(GEN_BUSY_O) |-> !TX_ER_O)
      else $error("error flag raised while generating");
   frame_open_a: assert property ($rose(TX_EN_O) && GEN_BUSY_O |->
      TX_EN_O throughout (preamble_s ##1 dest_fill_s)) else $error("bad frame opening");
   frame_len_a: assert property ($fell(TX_EN_O) && GEN_BUSY_O |-> hi_q == 16'h0048
      || hi_q == 16'h0085 || hi_q == 16'h05F6 || hi_q == 16'(JUMBO_BYTES + 8))
      else $error("frame length off");
   gap_len_a: assert property ($rose(TX_EN_O) && GEN_BUSY_O && gap_q > 11'h002 |->
      gap_q == 11'h00C || gap_q == 11'h400) else $error("gap length off");
   pat_read_a: assert property (pat_wr_s |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
      else $error("pattern readback wrong");
   start_tx_a: assert property (ctl_wr && REG_WDATA_I[15:14] == 2'b11 && !run_q && !GEN_BUSY_O
      |-> ##3 TX_EN_O && TX_DATA_O == 8'h55) else $error("late start");
   stop_idle_a: assert property (ctl_wr && !REG_WDATA_I[14] && !GEN_BUSY_O && !$past(ctl_wr)
      |=> !GEN_BUSY_O [*3]) else $error("started without run");
endmodule
bind tfg_top tfg_top_props #(.JUMBO_BYTES(JUMBO_BYTES)) u_props (.CLK_I(CLK_I),
   .NRST_I(NRST_I), .REG_PAGE1_I(REG_PAGE1_I), .REG_WE_I(REG_WE_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .MAC_TXD_I(MAC_TXD_I),
   .MAC_TX_EN_I(MAC_TX_EN_I), .MAC_TX_ER_I(MAC_TX_ER_I), .TX_DATA_O(TX_DATA_O),
   .TX_EN_O(TX_EN_O), .TX_ER_O(TX_ER_O), .GEN_BUSY_O(GEN_BUSY_O));

/* tb/tfg_link_partner.sv */
// link partner receiver: splits frames and checks their check sequence
`timescale 1ns/1ns
module tfg_link_partner (
   input wire logic clk_i,
   input wire tfg_pkg::tfg_byte_t data_i,
   input wire logic en_i,
   output logic done_o,
   output int unsigned len_o,
   output logic fcs_ok_o,
   output logic [3:0] da_o,
   output logic [3:0] sa_o,
   output logic [15:0] pay_o
);
   import tfg_pkg::*;
   int unsigned n = 0;
   logic [31:0] crc = 32'hFFFFFFFF;
   logic en_q = 1'b0;
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      c = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
      return c;
   endfunction
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (en_i) begin
         // crc runs over the fcs too, so a good frame leaves the fixed residue
         crc <= (n >= 8) ? crc_step(crc, data_i) : 32'hFFFFFFFF;
         if (n == 13) da_o <= data_i[3:0];
         if (n == 19) sa_o <= data_i[3:0];
         if (n == 22) pay_o[15:8] <= data_i;
         if (n == 23) pay_o[7:0] <= data_i;
         n <= n + 1;
      end else if (en_q) begin
         done_o <= 1'b1;
         len_o <= n - 8;
         fcs_ok_o <= (crc == 32'hDEBB20E3);
         n <= 0;
      end
      en_q <= en_i;
   end
endmodule

/* tb/tfg_top_bench.sv */
// self-checking bench for the test frame generator
`timescale 1ns/1ns
module tfg_top_bench;
   import tfg_pkg::*;
   localparam int unsigned JB = 100;
   localparam logic [15:0] LENS [4] = '{16'h007D, 16'h0040, 16'h05EE, 16'(JB)};
   logic CLK_I = 1'b0;
   logic NRST_I = 1'b0;
   logic REG_PAGE1_I = 1'b1;
   logic REG_WE_I = 1'b0;
   tfg_addr_t REG_ADDR_I = 5'h00;
   tfg_word_t REG_WDATA_I = 16'h0000;
   tfg_word_t REG_RDATA_O;
   tfg_byte_t MAC_TXD_I = 8'h00;
   logic MAC_TX_EN_I = 1'b0;
   logic MAC_TX_ER_I = 1'b0;
   tfg_byte_t TX_DATA_O;
   logic TX_EN_O;
   logic TX_ER_O;
   logic GEN_BUSY_O;
   logic lp_done;
   logic lp_ok;
   logic [3:0] lp_da;
   logic [3:0] lp_sa;
   logic [15:0] lp_pay;
   int unsigned lp_len;
   logic [41:0] exp_q[$];
   logic [41:0] e;
   logic [40:0] got;
   logic [15:0] rnd = 16'h004A;
   logic [15:0] rs = 16'h004A;
   logic mac_on = 1'b0;
   int n_fail = 0;
   int tests_run = 0;
   int n_frm = 0;
   tfg_top #(.FRAME_TOTAL(5), .BLOCK_FRAMES(3), .JUMBO_BYTES(JB)) DUT (.CLK_I(CLK_I),
      .NRST_I(NRST_I), .REG_PAGE1_I(REG_PAGE1_I), .REG_WE_I(REG_WE_I), .REG_ADDR_I(REG_ADDR_I),
      .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .MAC_TXD_I(MAC_TXD_I),
      .MAC_TX_EN_I(MAC_TX_EN_I), .MAC_TX_ER_I(MAC_TX_ER_I), .TX_DATA_O(TX_DATA_O),
      .TX_EN_O(TX_EN_O), .TX_ER_O(TX_ER_O), .GEN_BUSY_O(GEN_BUSY_O));
   tfg_link_partner u_lp (.clk_i(CLK_I), .data_i(TX_DATA_O), .en_i(TX_EN_O), .done_o(lp_done),
      .len_o(lp_len), .fcs_ok_o(lp_ok), .da_o(lp_da), .sa_o(lp_sa), .pay_o(lp_pay));
   always #50 CLK_I = ~CLK_I;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      tests_run++;
      if (seen !== want) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge CLK_I);
      #1;
      REG_ADDR_I = a;
      REG_WDATA_I = d;
      REG_WE_I = 1'b1;
      @(posedge CLK_I);
      #1;
      REG_WE_I = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] want);
      @(posedge CLK_I);
      #1;
      REG_ADDR_I = a;
      @(posedge CLK_I);
      #1;
      check(64'(REG_RDATA_O), 64'(want));
   endtask
   task automatic wait_idle();
      int i;
      for (i = 0; i < 20 && GEN_BUSY_O !== 1'b1; i++) @(posedge CLK_I);
      if (i == 20) begin
         n_fail++;
         stop_test();
      end
      mac_on = 1'b1;
      for (i = 0; i < 40000 && GEN_BUSY_O !== 1'b0; i++) @(posedge CLK_I);
      mac_on = 1'b0;
      if (i == 40000) begin
         n_fail++;
         stop_test();
      end
      repeat (3) @(posedge CLK_I);
   endtask
   // cut > 0 rewrites pattern and control once that many frames are seen; the run keeps its setup
   task automatic run(input logic [15:0] c, input int n, input logic [15:0] p, input int cut,
         input logic [15:0] c2);
      int k;
      int base;
      for (k = 0; k < n; k++) exp_q.push_back({c[1], LENS[c[12:11]], ~c[0], c[9:2], p});
      base = n_frm;
      wr(5'h1E, p);
      wr(5'h1D, 16'hC000 | c);
      for (k = 0; cut > 0 && k < 40000 && n_frm < base + cut; k++) @(posedge CLK_I);
      if (cut > 0 && n_frm < base + cut) begin
         n_fail++;
         stop_test();
      end
      if (cut > 0) begin
         wr(5'h1E, ~p);
         wr(5'h1D, c2);
      end
      wait_idle();
      check(64'(exp_q.size()), 64'h0);
      wr(5'h1D, 16'h0000);
   endtask
   always @(posedge CLK_I) begin
      #1;
      rnd = lfsr(rnd);
      MAC_TXD_I = rnd[7:0];
      MAC_TX_ER_I = rnd[8];
      MAC_TX_EN_I = rnd[9] & mac_on;
   end
   // frames that end while the generator owns the path are its own
   always @(negedge CLK_I) begin
      if (lp_done === 1'b1 && GEN_BUSY_O === 1'b1) begin
         n_frm++;
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 42'h0;
         if (e[41]) check(64'(lp_pay == e[15:0]), 64'h0);
         got = {16'(lp_len), lp_ok, lp_da, lp_sa, e[41] ? e[15:0] : lp_pay};
         check(64'(got), 64'(e[40:0]));
      end
   end
   initial begin
      logic [15:0] c;
      repeat (5) @(posedge CLK_I);
      #1;
      NRST_I = 1'b1;
      repeat (3) @(posedge CLK_I);
      rd(5'h1D, 16'h0040);
      rd(5'h1E, 16'h0000);
      rd(5'h1F, 16'h0000);
      REG_PAGE1_I = 1'b0;
      wr(5'h1E, 16'hA5C3);
      rd(5'h1E, 16'h0000);
      REG_PAGE1_I = 1'b1;
      rd(5'h1E, 16'h0000);
      run(16'h0400, 1, 16'h3C96, 1, 16'h8400);
      for (int j = 0; j < 4; j++) begin
         rs = lfsr(rs);
         run({3'b000, 2'(j), 1'(j == 1), rs[9:2], 2'(j)}, 5, lfsr(rs), 0, 16'h0000);
      end
      rs = lfsr(rs);
      c = {8'h28, rs[7:2], 2'b00};
      run(c, 6, rs, 4, 16'hC800 ^ (c & 16'hDFFF));
      stop_test();
   end
endmodule
